// ==== rtl/sshp_pkg.sv ====
// Purpose: Shared constants of the sensor serial host port
// Assumes: 50 MHz system clock
// Notes:   Link timing is given in Hz and derived to cycles
package sshp_pkg;
    localparam int          ADDR_W      = 7;
    localparam int          DATA_W      = 8;
    localparam int          REG_DEPTH   = 128;
    localparam int          SYNC_STAGES = 2;
    localparam logic [5:0]  TW_ADDR_HI  = 6'h34;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    localparam logic [3:0]  TW_BYTE_END = 4'h8;
    localparam logic [3:0]  TW_MACK_OK  = 4'h9;
    localparam logic [7:0]  REG_RST     = 8'h00;
    localparam int          CLK_HZ      = 50000000;
    localparam int          SCLK_MAX_HZ = 10000000;
    localparam int          SCLK_MIN_CYC = CLK_HZ / SCLK_MAX_HZ;
endpackage : sshp_pkg

// ==== rtl/sshp_reg_if.sv ====
// Purpose: Register access carrier between engine and store
// Assumes: Single clock domain
// Notes:   Read data is combinational from the store
`timescale 1ns/1ps
interface sshp_reg_if;
    logic [sshp_pkg::ADDR_W-1:0] addr;
    logic [sshp_pkg::DATA_W-1:0] wdata;
    logic                        we;
    logic [sshp_pkg::DATA_W-1:0] rdata;
    modport master (output addr, output wdata, output we, input rdata);
    modport store  (input addr, input wdata, input we, output rdata);
endinterface : sshp_reg_if

// ==== rtl/sshp_sync.sv ====
// Purpose: Two-stage synchroniser, one per bit
// Assumes: Inputs asynchronous to clk_sys
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module sshp_sync #(
    parameter int             W       = 4,
    // Idle pin levels, so release of reset shows no false edge or select
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // System
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_r <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : sshp_sync

// ==== rtl/sshp_regfile.sv ====
// Purpose: Internal register store reached from the host port
// Assumes: One write port, asynchronous read
// Notes:   Never refuses access, whatever the power mode
`timescale 1ns/1ps
module sshp_regfile (
    // System
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Access
    sshp_reg_if.store bus
);
    logic [sshp_pkg::DATA_W-1:0] mem_r [sshp_pkg::REG_DEPTH];

    assign bus.rdata = mem_r[bus.addr];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < sshp_pkg::REG_DEPTH; i++) begin
                mem_r[i] <= sshp_pkg::REG_RST;
            end
        end else if (bus.we) begin
            mem_r[bus.addr] <= bus.wdata;
        end
    end
endmodule : sshp_regfile

// ==== rtl/sshp_top.sv ====
// Purpose: Host port: two-wire and four-wire slave to registers
// Assumes: Link clock at most a fifth of clk_sys
// Notes:   Pins are sampled, so link edges lag by three cycles
//
// How it works
// - Two-wire frame opens when data falls while clock is high.
// - Two-wire frame closes when data rises while clock is high.
// - Receiver acknowledges by pulling data low on the ninth clock.
// - Data left high on the ninth clock is a not-acknowledge.
// - Four-wire port is slave only; never drives the clock.
// - Serial data output is released while select is high.
// - Four-wire bytes move most significant bit first.
// - Receiver samples four-wire data on clock rising edge.
// - Transmitter changes four-wire data on clock falling edge.
// - Four-wire transfer is a command byte plus data bytes.
// - First four-wire byte is the command, later bytes are data.
// - Command bit 7 set means read, clear means write.
// - Command bits 6 to 0 form the register address.
// - Single and burst reads and writes, data bits 7 to 0.
// - Register store never refuses access; two-wire frames are ignored while disabled.
// - Two-wire address is 110100 plus the address pin level.
// - Two-wire burst write advances the register address.
`timescale 1ns/1ps
module sshp_top #(
    parameter int REG_DEPTH = sshp_pkg::REG_DEPTH
) (
    // System
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Shared clock pin
    input  wire logic       scl_sclk_i,
    // Shared data pin, open-drain in two-wire use
    input  wire logic       sda_sdi_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Address strap pin doubling as serial data output
    input  wire logic       address_lsb_pin,
    output logic            sdo_o,
    output logic            sdo_oe,
    // Four-wire select
    input  wire logic       slave_select_low,
    // Configuration from the register space
    input  wire logic       two_wire_port_disable,
    // Write notice to the core
    output logic            reg_wr_pulse,
    output logic [6:0]      reg_wr_addr,
    output logic [7:0]      reg_wr_data
);
    if (REG_DEPTH != (1 << sshp_pkg::ADDR_W)) begin : g_chk
        $error("REG_DEPTH must equal 2**ADDR_W");
    end

    ////////////////////////////////////////////////////////////////
    // Pin sampling and edge detection

    logic [3:0] pin_s;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       scl_s;
    logic       sda_s;
    logic       ad0_s;
    logic       cs_n_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       tw_start;
    logic       tw_stop;

    sshp_sync #(.W(4), .RST_VAL(4'hD)) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .din     ({scl_sclk_i, sda_sdi_i, address_lsb_pin,
                   slave_select_low}),
        .dout    (pin_s)
    );

    assign scl_s  = pin_s[3];
    assign sda_s  = pin_s[2];
    assign ad0_s  = pin_s[1];
    assign cs_n_s = pin_s[0];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign tw_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign tw_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    ////////////////////////////////////////////////////////////////
    // Register store

    sshp_reg_if rif ();

    sshp_regfile u_regs (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .bus     (rif.store)
    );

    ////////////////////////////////////////////////////////////////
    // Four-wire engine; only samples the clock, never drives it

    logic [2:0] sp_bits_r, sp_bits_nxt;
    logic [7:0] sp_sh_r, sp_sh_nxt;
    logic [7:0] sp_tx_r, sp_tx_nxt;
    logic [6:0] sp_addr_r, sp_addr_nxt;
    logic       sp_first_r, sp_first_nxt;
    logic       sp_rd_r, sp_rd_nxt;
    logic       sp_load_r, sp_load_nxt;
    logic       sp_we_r, sp_we_nxt;
    logic [6:0] sp_wa_r, sp_wa_nxt;
    logic [7:0] sp_wd_r, sp_wd_nxt;
    logic       sdo_r, sdo_nxt;
    logic       sdo_oe_r, sdo_oe_nxt;
    logic [7:0] sp_byte;

    assign sp_byte = {sp_sh_r[6:0], sda_s};

    always_comb begin
        sp_bits_nxt  = sp_bits_r;
        sp_sh_nxt    = sp_sh_r;
        sp_tx_nxt    = sp_tx_r;
        sp_addr_nxt  = sp_addr_r;
        sp_first_nxt = sp_first_r;
        sp_rd_nxt    = sp_rd_r;
        sp_load_nxt  = 1'b0;
        sp_we_nxt    = 1'b0;
        sp_wa_nxt    = sp_wa_r;
        sp_wd_nxt    = sp_wd_r;
        sdo_nxt      = sdo_r;
        sdo_oe_nxt   = 1'b1;
        if (cs_n_s) begin
            sp_bits_nxt  = 3'h0;
            sp_first_nxt = 1'b1;
            sp_tx_nxt    = 8'h00;
            sdo_oe_nxt   = 1'b0;
        end else begin
            if (sp_load_r) begin
                sp_tx_nxt   = rif.rdata;
                sp_addr_nxt = sp_addr_r + 7'h01;
            end
            if (scl_rise) begin
                sp_sh_nxt   = sp_byte;
                sp_bits_nxt = sp_bits_r + 3'h1;
                if (sp_bits_r == sshp_pkg::BIT_LAST) begin
                    if (sp_first_r) begin
                        sp_first_nxt = 1'b0;
                        sp_rd_nxt    = sp_byte[7];
                        sp_addr_nxt  = sp_byte[6:0];
                        sp_load_nxt  = sp_byte[7];
                    end else if (sp_rd_r) begin
                        sp_load_nxt  = 1'b1;
                    end else begin
                        sp_we_nxt    = 1'b1;
                        sp_wa_nxt    = sp_addr_r;
                        sp_wd_nxt    = sp_byte;
                        sp_addr_nxt  = sp_addr_r + 7'h01;
                    end
                end
            end
            if (scl_fall) begin
                sdo_nxt   = sp_tx_r[7];
                sp_tx_nxt = {sp_tx_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sp_bits_r  <= 3'h0;
            sp_sh_r    <= 8'h00;
            sp_tx_r    <= 8'h00;
            sp_addr_r  <= 7'h00;
            sp_first_r <= 1'b1;
            sp_rd_r    <= 1'b0;
            sp_load_r  <= 1'b0;
            sp_we_r    <= 1'b0;
            sp_wa_r    <= 7'h00;
            sp_wd_r    <= 8'h00;
            sdo_r      <= 1'b0;
            sdo_oe_r   <= 1'b0;
        end else begin
            sp_bits_r  <= sp_bits_nxt;
            sp_sh_r    <= sp_sh_nxt;
            sp_tx_r    <= sp_tx_nxt;
            sp_addr_r  <= sp_addr_nxt;
            sp_first_r <= sp_first_nxt;
            sp_rd_r    <= sp_rd_nxt;
            sp_load_r  <= sp_load_nxt;
            sp_we_r    <= sp_we_nxt;
            sp_wa_r    <= sp_wa_nxt;
            sp_wd_r    <= sp_wd_nxt;
            sdo_r      <= sdo_nxt;
            sdo_oe_r   <= sdo_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Two-wire engine; idle while selected on four-wire

    typedef enum logic [6:0] {
        TW_IDLE = 7'h01,
        TW_DEV  = 7'h02,
        TW_IDX  = 7'h04,
        TW_WR   = 7'h08,
        TW_ACKD = 7'h10,
        TW_ACKW = 7'h20,
        TW_RD   = 7'h40
    } sshp_tw_e;

    sshp_tw_e   tw_st_r, tw_st_nxt;
    logic       tw_mack_r, tw_mack_nxt;
    logic [3:0] tw_cnt_r, tw_cnt_nxt;
    logic [7:0] tw_sh_r, tw_sh_nxt;
    logic [7:0] tw_tx_r, tw_tx_nxt;
    logic [6:0] tw_addr_r, tw_addr_nxt;
    logic       tw_rnw_r, tw_rnw_nxt;
    logic       tw_oe_r, tw_oe_nxt;
    logic       tw_we_r, tw_we_nxt;
    logic [6:0] tw_wa_r, tw_wa_nxt;
    logic [7:0] tw_wd_r, tw_wd_nxt;
    logic       ad0_r, ad0_nxt;
    logic       tw_en;
    logic       tw_load;

    // Disable bit guards against stray starts on shared pins
    assign tw_en = cs_n_s & ~two_wire_port_disable;

    always_comb begin
        tw_st_nxt   = tw_st_r;
        tw_mack_nxt = tw_mack_r;
        tw_cnt_nxt  = tw_cnt_r;
        tw_sh_nxt   = tw_sh_r;
        tw_tx_nxt   = tw_tx_r;
        tw_addr_nxt = tw_addr_r;
        tw_rnw_nxt  = tw_rnw_r;
        tw_oe_nxt   = tw_oe_r;
        tw_we_nxt   = 1'b0;
        tw_wa_nxt   = tw_wa_r;
        tw_wd_nxt   = tw_wd_r;
        ad0_nxt     = ad0_r;
        tw_load     = 1'b0;
        if (!tw_en) begin
            tw_st_nxt   = TW_IDLE;
            tw_mack_nxt = 1'b0;
            tw_oe_nxt   = 1'b0;
        end else if (tw_start) begin
            tw_st_nxt   = TW_DEV;
            tw_mack_nxt = 1'b0;
            tw_cnt_nxt  = 4'h0;
            tw_oe_nxt   = 1'b0;
        end else if (tw_stop) begin
            tw_st_nxt   = TW_IDLE;
            tw_mack_nxt = 1'b0;
            tw_oe_nxt   = 1'b0;
        end else if (tw_mack_r) begin
            if (scl_rise) begin
                if (sda_s) begin
                    tw_mack_nxt = 1'b0;
                    tw_st_nxt   = TW_IDLE;
                end else begin
                    tw_cnt_nxt  = sshp_pkg::TW_MACK_OK;
                end
            end else if (scl_fall &&
                         tw_cnt_r == sshp_pkg::TW_MACK_OK) begin
                tw_mack_nxt = 1'b0;
                tw_load     = 1'b1;
            end
        end else begin
            unique case (tw_st_r)
                TW_IDLE: begin
                    ad0_nxt = ad0_s;
                end
                TW_DEV, TW_IDX, TW_WR: begin
                    if (scl_rise) begin
                        tw_sh_nxt  = {tw_sh_r[6:0], sda_s};
                        tw_cnt_nxt = tw_cnt_r + 4'h1;
                    end else if (scl_fall &&
                                 tw_cnt_r == sshp_pkg::TW_BYTE_END) begin
                        tw_cnt_nxt = 4'h0;
                        tw_oe_nxt  = 1'b1;
                        tw_st_nxt  = TW_ACKW;
                        if (tw_st_r == TW_DEV) begin
                            if (tw_sh_r[7:1] ==
                                {sshp_pkg::TW_ADDR_HI, ad0_r}) begin
                                tw_rnw_nxt = tw_sh_r[0];
                                tw_st_nxt  = TW_ACKD;
                            end else begin
                                tw_oe_nxt  = 1'b0;
                                tw_st_nxt  = TW_IDLE;
                            end
                        end else if (tw_st_r == TW_IDX) begin
                            tw_addr_nxt = tw_sh_r[6:0];
                        end else begin
                            tw_we_nxt   = 1'b1;
                            tw_wa_nxt   = tw_addr_r;
                            tw_wd_nxt   = tw_sh_r;
                            tw_addr_nxt = tw_addr_r + 7'h01;
                        end
                    end
                end
                TW_ACKD: begin
                    if (scl_fall) begin
                        tw_oe_nxt = 1'b0;
                        if (tw_rnw_r) begin
                            tw_load = 1'b1;
                        end else begin
                            tw_st_nxt = TW_IDX;
                        end
                    end
                end
                TW_ACKW: begin
                    if (scl_fall) begin
                        tw_oe_nxt = 1'b0;
                        tw_st_nxt = TW_WR;
                    end
                end
                TW_RD: begin
                    if (scl_fall) begin
                        if (tw_cnt_r == sshp_pkg::TW_BYTE_END) begin
                            tw_oe_nxt   = 1'b0;
                            tw_cnt_nxt  = 4'h0;
                            tw_mack_nxt = 1'b1;
                        end else begin
                            tw_oe_nxt  = ~tw_tx_r[7];
                            tw_tx_nxt  = {tw_tx_r[6:0], 1'b0};
                            tw_cnt_nxt = tw_cnt_r + 4'h1;
                        end
                    end
                end
            endcase
        end
        if (tw_load) begin
            tw_st_nxt   = TW_RD;
            tw_oe_nxt   = ~rif.rdata[7];
            tw_tx_nxt   = {rif.rdata[6:0], 1'b0};
            tw_cnt_nxt  = 4'h1;
            tw_addr_nxt = tw_addr_r + 7'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tw_st_r   <= TW_IDLE;
            tw_mack_r <= 1'b0;
            tw_cnt_r  <= 4'h0;
            tw_sh_r   <= 8'h00;
            tw_tx_r   <= 8'h00;
            tw_addr_r <= 7'h00;
            tw_rnw_r  <= 1'b0;
            tw_oe_r   <= 1'b0;
            tw_we_r   <= 1'b0;
            tw_wa_r   <= 7'h00;
            tw_wd_r   <= 8'h00;
            ad0_r     <= 1'b0;
        end else begin
            tw_st_r   <= tw_st_nxt;
            tw_mack_r <= tw_mack_nxt;
            tw_cnt_r  <= tw_cnt_nxt;
            tw_sh_r   <= tw_sh_nxt;
            tw_tx_r   <= tw_tx_nxt;
            tw_addr_r <= tw_addr_nxt;
            tw_rnw_r  <= tw_rnw_nxt;
            tw_oe_r   <= tw_oe_nxt;
            tw_we_r   <= tw_we_nxt;
            tw_wa_r   <= tw_wa_nxt;
            tw_wd_r   <= tw_wd_nxt;
            ad0_r     <= ad0_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Access steering and pin outputs

    // Engines never write together: two-wire idles while selected
    always_comb begin
        rif.we    = sp_we_r | tw_we_r;
        rif.wdata = sp_we_r ? sp_wd_r : tw_wd_r;
        if (sp_we_r) begin
            rif.addr = sp_wa_r;
        end else if (tw_we_r) begin
            rif.addr = tw_wa_r;
        end else if (!cs_n_s) begin
            rif.addr = sp_addr_r;
        end else begin
            rif.addr = tw_addr_r;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_wr_pulse <= 1'b0;
            reg_wr_addr  <= 7'h00;
            reg_wr_data  <= 8'h00;
            sda_o        <= 1'b0;
        end else begin
            reg_wr_pulse <= rif.we;
            reg_wr_addr  <= rif.addr;
            reg_wr_data  <= rif.wdata;
            sda_o        <= 1'b0;
        end
    end

    assign sda_oe = tw_oe_r;
    assign sdo_o  = sdo_r;
    assign sdo_oe = sdo_oe_r;
endmodule : sshp_top

// ==== bench/sshp_top_chk.sv ====
// Purpose: Port checks of the sensor serial host port
// Assumes: Pins reach the logic through a three-cycle lag
// Notes:   Windows of five or six cycles absorb that lag
`timescale 1ns/1ps
module sshp_top_chk (
    // System
    input wire logic clk_sys,
    input wire logic nrst,
    // Link pins
    input wire logic scl_sclk_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic slave_select_low,
    input wire logic two_wire_port_disable,
    // Write notice
    input wire logic reg_wr_pulse
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    a_sdo_released: assert property (
        slave_select_low [*5] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    a_sdo_driven: assert property (
        !slave_select_low [*5] |-> sdo_oe)
        else $error("sdo idle while selected");
    a_sdo_on_fall: assert property (
        sdo_oe && $past(sdo_oe, 2) && $changed(sdo_o)
        |-> !$past(scl_sclk_i) && !$past(scl_sclk_i, 2))
        else $error("sdo moved outside clock low");
    a_sda_on_low: assert property (
        $changed(sda_oe) |-> !$past(scl_sclk_i) && !$past(scl_sclk_i, 2))
        else $error("sda drive moved while clock high");
    a_sda_open_drain: assert property (
        sda_oe |-> !sda_o)
        else $error("sda driven high");
    a_sda_quiet_spi: assert property (
        !slave_select_low [*6] |-> !sda_oe)
        else $error("sda driven during four-wire frame");
    a_sda_disabled: assert property (
        two_wire_port_disable [*6] |-> !sda_oe)
        else $error("sda driven while two-wire disabled");
    a_wr_single: assert property (
        reg_wr_pulse |=> !reg_wr_pulse [*8])
        else $error("write notice longer than one cycle");
endmodule : sshp_top_chk

// ==== bench/sshp_host.sv ====
// Purpose: Host processor model, four-wire and two-wire master
// Assumes: Link half period of 80 ns, phase free of clk_sys
// Notes:   Clock stands still between frames
`timescale 1ns/1ps
module sshp_host (
    // Link drives
    output logic scl,
    output logic sda,
    output logic sel_low,
    // Link returns
    input  wire logic sda_in,
    input  wire logic sdo_in
);
    localparam int H = 80;
    initial begin
        scl = 1'b0;
        sda = 1'b1;
        sel_low = 1'b1;
    end
    ////////////////////////////////////////
    // One select line, ours only
    task automatic spi_open();
        scl = 1'b0;
        #(H) sel_low = 1'b0;
        #(H);
    endtask : spi_open
    task automatic spi_close();
        #(H) sel_low = 1'b1;
        sda = 1'b1;
        #(2*H);
    endtask : spi_close
    // Mode 0, 6.25 MHz keeps margin on the sync lag
    task automatic spi_bits(input logic [7:0] tx, input int n,
                            output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sda = tx[3'(i)];
            #(H) scl = 1'b1;
            rx[3'(i)] = sdo_in;
            #(H) scl = 1'b0;
        end
    endtask : spi_bits
    ////////////////////////////////////////
    task automatic i2c_start();
        sda = 1'b1;
        #(H) scl = 1'b1;
        #(H) sda = 1'b0;
        #(H) scl = 1'b0;
    endtask : i2c_start
    task automatic i2c_stop();
        #20 sda = 1'b0;
        #(H) scl = 1'b1;
        #(H) sda = 1'b1;
        #(H);
    endtask : i2c_stop
    // Data moves only while the clock is low
    task automatic i2c_wr(input logic [7:0] tx, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            #20 sda = (i < 0) ? 1'b1 : tx[3'(i)];
            #(H-20) scl = 1'b1;
            #(H-10) ack = !sda_in;
            #10 scl = 1'b0;
        end
    endtask : i2c_wr
    task automatic i2c_rd(input logic nack, output logic [7:0] rx);
        for (int i = 7; i >= -1; i--) begin
            #20 sda = (i < 0) ? nack : 1'b1;
            #(H-20) scl = 1'b1;
            #(H-10) if (i >= 0) rx[3'(i)] = sda_in;
            #10 scl = 1'b0;
        end
        #20 sda = 1'b1;
    endtask : i2c_rd
endmodule : sshp_host

// ==== bench/tb.sv ====
// Purpose: Self-checking bench of the sensor serial host port
// Assumes: Host model on the link, register image kept here
// Notes:   Write notices are queued and compared per transfer
`timescale 1ns/1ps
module tb;
    logic        clk_sys;
    logic        nrst;
    logic        two_wire_port_disable;
    logic        scl, host_sda, sel_low, ad_pin, sda_w, sdo_w;
    logic        sda_o, sda_oe, sdo_o, sdo_oe, reg_wr_pulse;
    logic [6:0]  reg_wr_addr;
    logic [7:0]  reg_wr_data;
    logic        ack;
    logic [7:0]  rx;
    logic [14:0] got_q[$];
    logic [14:0] exp_q[$];
    int          mem [128];
    int          err_total;
    int          check_count;
    // Pull-up on data; pin 1 shows the strap when released
    assign sda_w = host_sda & !(sda_oe & !sda_o);
    assign sdo_w = sdo_oe ? sdo_o : ad_pin;
    sshp_top sshp_top_inst (.clk_sys, .nrst, .scl_sclk_i(scl),
        .sda_sdi_i(sda_w), .sda_o, .sda_oe, .address_lsb_pin(ad_pin),
        .sdo_o, .sdo_oe, .slave_select_low(sel_low),
        .two_wire_port_disable, .reg_wr_pulse, .reg_wr_addr,
        .reg_wr_data);
    sshp_host sshp_host_inst (.scl, .sda(host_sda), .sel_low,
        .sda_in(sda_w), .sdo_in(sdo_w));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (reg_wr_pulse === 1'b1) got_q.push_back({reg_wr_addr, reg_wr_data});
    end
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic set_in(input logic dis, input logic ad);
        @(posedge clk_sys);
        #2 two_wire_port_disable = dis;
        ad_pin = ad;
        repeat (4) @(posedge clk_sys);
        #2;
    endtask : set_in
    task automatic cmp_wr();
        chk("write count", 16'(got_q.size()), 16'(exp_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0)
            chk("write", {1'b0, got_q.pop_front()}, {1'b0, exp_q.pop_front()});
        got_q.delete();
        exp_q.delete();
    endtask : cmp_wr
    task automatic put(input logic [6:0] a, input int i, output logic [7:0] d);
        d = 8'($urandom);
        mem[(a + i) % 128] = d;
        exp_q.push_back({7'((a + i) % 128), d});
    endtask : put
    ////////////////////////////////////////
    task automatic spi_wr(input logic [6:0] a, input int n);
        logic [7:0] d;
        sshp_host_inst.spi_open();
        sshp_host_inst.spi_bits({1'b0, a}, 8, d);
        for (int i = 0; i < n; i++) begin
            put(a, i, d);
            sshp_host_inst.spi_bits(d, 8, d);
        end
        sshp_host_inst.spi_close();
        cmp_wr();
    endtask : spi_wr
    task automatic spi_rd(input logic [6:0] a, input int n);
        logic [7:0] d;
        sshp_host_inst.spi_open();
        sshp_host_inst.spi_bits({1'b1, a}, 8, d);
        for (int i = 0; i < n; i++) begin
            sshp_host_inst.spi_bits(8'h00, 8, d);
            chk("spi read", {8'h00, d}, 16'(mem[(a + i) % 128]));
        end
        sshp_host_inst.spi_close();
    endtask : spi_rd
    task automatic tw_wr(input logic [6:0] dev, input logic [6:0] a,
                         input int n, input logic hit);
        logic [7:0] d;
        sshp_host_inst.i2c_start();
        sshp_host_inst.i2c_wr({dev, 1'b0}, ack);
        chk("address ack", {15'h0, ack}, {15'h0, hit});
        if (hit) begin
            sshp_host_inst.i2c_wr({1'b0, a}, ack);
            for (int i = 0; i < n; i++) begin
                put(a, i, d);
                sshp_host_inst.i2c_wr(d, ack);
                chk("data ack", {15'h0, ack}, 16'h0001);
            end
        end
        sshp_host_inst.i2c_stop();
        cmp_wr();
    endtask : tw_wr
    task automatic tw_rd(input logic [6:0] dev, input logic [6:0] a,
                         input int n);
        logic [7:0] d;
        sshp_host_inst.i2c_start();
        sshp_host_inst.i2c_wr({dev, 1'b0}, ack);
        sshp_host_inst.i2c_wr({1'b0, a}, ack);
        sshp_host_inst.i2c_start();
        sshp_host_inst.i2c_wr({dev, 1'b1}, ack);
        chk("read ack", {15'h0, ack}, 16'h0001);
        for (int i = 0; i < n; i++) begin
            sshp_host_inst.i2c_rd(i == n - 1, d);
            chk("i2c read", {8'h00, d}, 16'(mem[(a + i) % 128]));
        end
        sshp_host_inst.i2c_stop();
    endtask : tw_rd
    ////////////////////////////////////////
    initial begin
        err_total = 0;
        check_count = 0;
        nrst = 1'b0;
        two_wire_port_disable = 1'b1;
        ad_pin = 1'b0;
        void'($urandom(37202));
        repeat (20) @(posedge clk_sys);
        chk("reset outputs", {13'h0, sda_oe, sdo_oe, reg_wr_pulse}, 16'h0);
        #2 nrst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #2 chk("sdo after reset", {15'h0, sdo_oe}, 16'h0);
        repeat (2) @(posedge clk_sys);
        #2;
        spi_wr(7'h05, 1);
        spi_wr(7'h7E, 3);
        repeat (3) spi_wr(7'($urandom), 1 + $urandom % 4);
        spi_rd(7'h7E, 4);
        spi_rd(7'h05, 1);
        // Frame cut mid-byte must leave no write behind
        sshp_host_inst.spi_open();
        sshp_host_inst.spi_bits(8'h10, 8, rx);
        sshp_host_inst.spi_bits(8'hA5, 5, rx);
        sshp_host_inst.spi_close();
        cmp_wr();
        spi_wr(7'h10, 2);
        for (int s = 0; s < 2; s++) begin
            set_in(1'b0, s[0]);
            tw_wr({6'h34, s[0]}, 7'h20, 2, 1'b1);
            tw_wr({6'h34, !s[0]}, 7'h30, 1, 1'b0);
            tw_rd({6'h34, s[0]}, 7'h7F, 3);
        end
        set_in(1'b1, 1'b1);
        tw_wr(7'h69, 7'h40, 1, 1'b0);
        spi_rd(7'h20, 2);
        give_verdict();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end
endmodule : tb
bind sshp_top sshp_top_chk sshp_top_chk_inst (.clk_sys, .nrst, .scl_sclk_i,
    .sda_o, .sda_oe, .sdo_o, .sdo_oe, .slave_select_low,
    .two_wire_port_disable, .reg_wr_pulse);
